// ### cfgmag_pkg.sv
// constants, field layout and types shared by the host-port design
package cfgmag_pkg;

	localparam int USER_WORDS = 32;
	localparam int WORD_BITS  = 16;

	////////////////////////////////////////////////////////////////////////
	// configuration word offsets
	localparam logic [4:0] W_SPIN    = 5'h00;
	localparam logic [4:0] W_MODE    = 5'h01;
	localparam logic [4:0] W_CONV    = 5'h02;
	localparam logic [4:0] W_SENS    = 5'h03;
	localparam logic [4:0] W_OFS_X   = 5'h04;
	localparam logic [4:0] W_OFS_Y   = 5'h05;
	localparam logic [4:0] W_OFS_Z   = 5'h06;
	localparam logic [4:0] W_WAKE_XY = 5'h07;
	localparam logic [4:0] W_WAKE_Z  = 5'h08;
	localparam logic [4:0] W_WAKE_T  = 5'h09;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int F_SPIN_LO = 0;
	localparam int F_ADDR_LO = 4;
	localparam int F_RATE_LO = 0;
	localparam int F_AXES_LO = 6;
	localparam int F_TEMP_COMPENSATION    = 10;
	localparam int F_TRIG_EN = 11;
	localparam int F_REL     = 12;
	localparam int F_HOST_LO = 13;
	localparam int F_TRIG_DIR = 15;
	localparam int F_OSR_LO  = 0;
	localparam int F_AVG_LO  = 2;
	localparam int F_WIN_LO  = 5;
	localparam int F_TEMPERATURE_OVERSAMPLING_LO = 11;
	localparam int F_SENS_HT_LO = 8;

	////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic [15:0] W_SPIN_RST = 16'h003C;
	localparam logic [15:0] W_MODE_RST = 16'h0000;
	localparam logic [15:0] W_CONV_RST = 16'h0000;
	localparam logic [15:0] W_ZERO_RST = 16'h0000;
	localparam logic [5:0]  PIN_IDLE   = 6'h07;

	////////////////////////////////////////////////////////////////////////
	// command codes and host selection
	localparam logic [3:0] OP_NOP  = 4'h0;
	localparam logic [3:0] OP_SB   = 4'h1;
	localparam logic [3:0] OP_SWOC = 4'h2;
	localparam logic [3:0] OP_SM   = 4'h3;
	localparam logic [3:0] OP_RM   = 4'h4;
	localparam logic [3:0] OP_RR   = 4'h5;
	localparam logic [3:0] OP_WR   = 4'h6;
	localparam logic [3:0] OP_EX   = 4'h8;
	localparam logic [3:0] OP_HR   = 4'hD;
	localparam logic [3:0] OP_HS   = 4'hE;
	localparam logic [3:0] OP_RT   = 4'hF;
	localparam logic [1:0] HOST_SPI_ONLY = 2'h2;
	localparam logic [1:0] HOST_I2C_ONLY = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// scales and timing
	localparam logic [6:0] SPIN_BASE_CLOCKS = 7'h08;
	localparam logic [9:0] DECIM_BASE       = 10'h040;
	localparam int CLK_KHZ        = 250000;
	localparam int REPEAT_STEP_MS = 20;
	localparam int REPEAT_STEP_CYC = REPEAT_STEP_MS * CLK_KHZ;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK  = 4'h8;

	typedef enum logic [1:0] {
		LNK_IDLE,
		LNK_ADDR,
		LNK_WRITE,
		LNK_READ
	} cfgmag_link_t;

endpackage

// ### cfgmag_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module cfgmag_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] IDLE = '0
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] level
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_r <= IDLE;
			s2_r <= IDLE;
			s3_r <= IDLE;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (sys_rst)
				level[i] <= IDLE[i];
			else if (s2_r[i] == s3_r[i])
				level[i] <= s3_r[i];
		end
	end
endmodule
`default_nettype wire

// ### cfgmag_repeat.sv
// idle-interval timer between repeated measurements
`timescale 1ns/100ps
`default_nettype none
module cfgmag_repeat #(
	parameter int STEP = 5000000
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic       done,
	input  wire logic [5:0] interval,
	output var  logic       fire
);
	logic [31:0] step_r;
	logic [5:0]  left_r;
	logic        wait_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			step_r <= 32'h00000000;
			left_r <= 6'h00;
			wait_r <= 1'b0;
			fire   <= 1'b0;
		end else begin
			fire <= 1'b0;
			if (!run) begin
				wait_r <= 1'b0;
			end else if (done) begin
				wait_r <= 1'b1;
				left_r <= interval;
				step_r <= 32'h00000000;
			end else if (wait_r) begin
				if (left_r == 6'h00) begin
					fire   <= 1'b1;
					wait_r <= 1'b0;
				end else if (step_r == 32'(STEP - 1)) begin
					step_r <= 32'h00000000;
					left_r <= left_r - 6'h01;
				end else begin
					step_r <= step_r + 32'h00000001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### cfgmag_port.sv
// serial host port, command engine and configuration memory
`timescale 1ns/100ps
`default_nettype none
module cfgmag_port #(
	parameter int REPEAT_STEP = cfgmag_pkg::REPEAT_STEP_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        sclk_pin,
	input  wire logic        cs_n_pin,
	input  wire logic        sda_in,
	output var  logic        sda_out,
	output var  logic        sda_oe_n,
	output var  logic        miso_out,
	output var  logic        miso_oe_n,
	input  wire logic        addr_select_pin_low,
	input  wire logic        addr_select_pin_high,
	input  wire logic        trig_in,
	output var  logic        trig_out,
	output var  logic        trig_oe_n,
	output var  logic        meas_start,
	output var  logic [3:0]  meas_axes,
	input  wire logic        meas_done,
	input  wire logic [15:0] result_z,
	input  wire logic [15:0] result_y,
	input  wire logic [15:0] result_x,
	input  wire logic [15:0] result_t,
	input  wire logic        temp_above_35c,
	output var  logic        result_ready_flag,
	output var  logic        wake_on_change_mode,
	output var  logic        change_compare_relative,
	output var  logic [6:0]  spin_phase_clocks,
	output var  logic [3:0]  chop_periods,
	output var  logic [9:0]  mag_decimation,
	output var  logic [9:0]  temp_decimation,
	output var  logic [7:0]  average_count,
	output var  logic        cfg_pair_invalid,
	output var  logic [5:0]  axis_output_window,
	output var  logic        temp_comp_enable,
	output var  logic [7:0]  sens_drift_active,
	output var  logic [15:0] offset_x,
	output var  logic [15:0] offset_y,
	output var  logic [15:0] offset_z,
	output var  logic [15:0] wake_xy_threshold,
	output var  logic [15:0] wake_zaxis_threshold,
	output var  logic [15:0] wake_temp_threshold
);
	import cfgmag_pkg::*;

	function automatic logic [15:0] cfg_default(input logic [4:0] a);
		case (a)
			W_SPIN:  return W_SPIN_RST;
			W_MODE:  return W_MODE_RST;
			W_CONV:  return W_CONV_RST;
			default: return W_ZERO_RST;
		endcase
	endfunction

	function automatic logic [2:0] cmd_len(input logic [3:0] op);
		case (op)
			OP_RR:   return 3'h2;
			OP_WR:   return 3'h4;
			default: return 3'h1;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin sampling
	logic [5:0] pin_s;
	logic [5:0] pin_d_r;

	cfgmag_sync #(.W(6), .IDLE(PIN_IDLE)) u_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in ({addr_select_pin_high, addr_select_pin_low, trig_in,
			sda_in, cs_n_pin, sclk_pin}),
		.level    (pin_s)
	);

	always_ff @(posedge clk) begin
		pin_d_r <= sys_rst ? PIN_IDLE : pin_s;
	end

	wire scl       = pin_s[0];
	wire cs_n      = pin_s[1];
	wire sda       = pin_s[2];
	wire trig      = pin_s[3];
	wire scl_rise  = scl & ~pin_d_r[0];
	wire scl_fall  = ~scl & pin_d_r[0];
	wire trig_rise = trig & ~pin_d_r[3];

	////////////////////////////////////////////////////////////////////////
	// configuration memory and field decode
	logic [15:0] vol_r [USER_WORDS];
	logic [15:0] nv_r  [USER_WORDS];
	logic        do_recall;
	logic        do_store;
	logic        do_write;
	logic [4:0]  wr_addr;
	logic [15:0] wr_data;

	for (genvar i = 0; i < USER_WORDS; i++) begin : g_word
		always_ff @(posedge clk) begin
			if (sys_rst)
				vol_r[i] <= cfg_default(5'(i));
			else if (do_recall)
				vol_r[i] <= nv_r[i];
			else if (do_write && wr_addr == 5'(i))
				vol_r[i] <= wr_data;
		end
		always_ff @(posedge clk) begin
			if (sys_rst)
				nv_r[i] <= cfg_default(5'(i));
			else if (do_store)
				nv_r[i] <= vol_r[i];
		end
	end

	wire [15:0] w_spin = vol_r[W_SPIN];
	wire [15:0] w_mode = vol_r[W_MODE];
	wire [15:0] w_conv = vol_r[W_CONV];
	wire [15:0] w_sens = vol_r[W_SENS];
	wire [3:0]  spin_f = w_spin[F_SPIN_LO+:4];
	wire [4:0]  addr_hi = w_spin[F_ADDR_LO+:5];
	wire [5:0]  rate_f = w_mode[F_RATE_LO+:6];
	wire [3:0]  def_axes = w_mode[F_AXES_LO+:4];
	wire        trig_en = w_mode[F_TRIG_EN];
	wire        trig_dir = w_mode[F_TRIG_DIR];
	wire [1:0]  host_sel = w_mode[F_HOST_LO+:2];
	wire [1:0]  osr_f = w_conv[F_OSR_LO+:2];
	wire [2:0]  avg_f = w_conv[F_AVG_LO+:3];

	assign spin_phase_clocks = SPIN_BASE_CLOCKS << spin_f[3:2];
	assign chop_periods = 4'h1 << spin_f[1:0];
	assign mag_decimation = DECIM_BASE << osr_f;
	assign temp_decimation = DECIM_BASE << w_conv[F_TEMPERATURE_OVERSAMPLING_LO+:2];
	assign average_count = 8'h01 << avg_f;
	assign cfg_pair_invalid = (osr_f == 2'h0 && avg_f < 3'h2) ||
		(osr_f == 2'h1 && avg_f == 3'h0);
	assign axis_output_window = w_conv[F_WIN_LO+:6];
	assign temp_comp_enable = w_mode[F_TEMP_COMPENSATION];
	assign change_compare_relative = w_mode[F_REL];
	assign sens_drift_active = temp_above_35c ?
		w_sens[F_SENS_HT_LO+:8] : w_sens[7:0];
	assign offset_x = temp_comp_enable ? vol_r[W_OFS_X] : 16'h0000;
	assign offset_y = temp_comp_enable ? vol_r[W_OFS_Y] : 16'h0000;
	assign offset_z = temp_comp_enable ? vol_r[W_OFS_Z] : 16'h0000;
	assign wake_xy_threshold = vol_r[W_WAKE_XY];
	assign wake_zaxis_threshold = vol_r[W_WAKE_Z];
	assign wake_temp_threshold = vol_r[W_WAKE_T];

	////////////////////////////////////////////////////////////////////////
	// link decode
	cfgmag_link_t link_r;
	logic [3:0]  bitcnt_r;
	logic [7:0]  rx_r;
	logic [7:0]  cmd_r [4];
	logic [2:0]  cmd_cnt_r;
	logic        cmd_full_r;
	logic        resp_ph_r;
	logic [3:0]  idx_r;
	logic        ack_r;
	logic        send_r;
	logic        exec_r;
	logic        pend_r;
	logic        stale_r;
	logic [7:0]  tx_byte;

	wire i2c_en = host_sel != HOST_SPI_ONLY;
	wire spi_en = host_sel != HOST_I2C_ONLY;
	wire spi_sel = spi_en & ~cs_n;
	wire spi_begin = spi_sel & pin_d_r[1];
	wire i2c_bus = i2c_en & cs_n;
	wire scl_hold = scl & pin_d_r[0];
	wire i2c_start = i2c_bus & scl_hold & ~sda & pin_d_r[2];
	wire i2c_stop = i2c_bus & scl_hold & sda & ~pin_d_r[2];
	wire i2c_on = link_r != LNK_IDLE;
	wire [7:0] rx_nxt = {rx_r[6:0], sda};
	wire byte_end = scl_rise & (bitcnt_r == BIT_LAST) & (spi_sel | i2c_on);
	wire spi_cmd_byte = byte_end & spi_sel & ~resp_ph_r;
	wire i2c_addr_byte = byte_end & ~spi_sel & (link_r == LNK_ADDR);
	wire i2c_cmd_byte = byte_end & ~spi_sel & (link_r == LNK_WRITE);
	wire cmd_byte = spi_cmd_byte | (i2c_cmd_byte & ~cmd_full_r);
	wire [3:0] first_op = (cmd_cnt_r == 3'h0) ? rx_nxt[7:4] : cmd_r[0][7:4];
	wire cmd_last = cmd_byte & ((cmd_cnt_r + 3'h1) == cmd_len(first_op));
	wire addr_match = rx_nxt[7:1] == {addr_hi, pin_s[5], pin_s[4]};
	wire read_end = byte_end & (spi_sel ? resp_ph_r : link_r == LNK_READ);
	wire tx_bit = tx_byte[3'h7 - bitcnt_r[2:0]];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			link_r <= LNK_IDLE;
			bitcnt_r <= 4'h0;
			rx_r <= 8'h00;
			cmd_r <= '{default: 8'h00};
			cmd_cnt_r <= 3'h0;
			cmd_full_r <= 1'b0;
			resp_ph_r <= 1'b0;
			idx_r <= 4'h0;
			ack_r <= 1'b0;
			send_r <= 1'b0;
			exec_r <= 1'b0;
		end else begin
			exec_r <= cmd_last;
			if (cmd_byte) begin
				cmd_r[cmd_cnt_r[1:0]] <= rx_nxt;
				cmd_cnt_r <= cmd_cnt_r + 3'h1;
				cmd_full_r <= cmd_last;
			end
			if (spi_begin) begin
				bitcnt_r <= 4'h0;
				resp_ph_r <= 1'b0;
				cmd_cnt_r <= 3'h0;
				cmd_full_r <= 1'b0;
				link_r <= LNK_IDLE;
			end else if (i2c_start) begin
				link_r <= LNK_ADDR;
				bitcnt_r <= 4'h0;
				ack_r <= 1'b0;
			end else if (i2c_stop || (!i2c_bus && i2c_on)) begin
				link_r <= LNK_IDLE;
			end else if (scl_rise && (spi_sel || i2c_on)) begin
				rx_r <= rx_nxt;
				bitcnt_r <= ((spi_sel && bitcnt_r == BIT_LAST) ||
					bitcnt_r == BIT_ACK) ? 4'h0 : bitcnt_r + 4'h1;
				if (read_end)
					idx_r <= idx_r + 4'h1;
				if (spi_cmd_byte && cmd_last) begin
					resp_ph_r <= 1'b1;
					idx_r <= 4'h0;
				end
				if (i2c_addr_byte) begin
					if (addr_match) begin
						ack_r <= 1'b1;
						link_r <= rx_nxt[0] ? LNK_READ : LNK_WRITE;
						idx_r <= 4'h0;
						send_r <= 1'b1;
						if (!rx_nxt[0]) begin
							cmd_cnt_r <= 3'h0;
							cmd_full_r <= 1'b0;
						end
					end else begin
						link_r <= LNK_IDLE;
					end
				end
				if (i2c_cmd_byte)
					ack_r <= ~cmd_full_r;
				if (!spi_sel && bitcnt_r == BIT_ACK) begin
					ack_r <= 1'b0;
					if (link_r == LNK_READ && !ack_r)
						send_r <= ~sda;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sda_oe_n <= 1'b1;
			miso_out <= 1'b1;
		end else if (spi_sel || i2c_stop || !i2c_on) begin
			sda_oe_n <= 1'b1;
			if (scl_fall)
				miso_out <= tx_bit;
		end else if (scl_fall) begin
			sda_oe_n <= ~((bitcnt_r == BIT_ACK && ack_r) ||
				(link_r == LNK_READ && send_r && !bitcnt_r[3] && !tx_bit));
		end
	end

	assign sda_out = 1'b0;
	assign miso_oe_n = ~(spi_sel & resp_ph_r);

	////////////////////////////////////////////////////////////////////////
	// command execution and measurement control
	logic        burst_r;
	logic        woc_r;
	logic        sm_r;
	logic        err_r;
	logic        rs_r;
	logic        ready_r;
	logic        active_r;
	logic        rm_done_r;
	logic [2:0]  len_r;
	logic [7:0]  data_r [8];
	logic [7:0]  resp_nxt [8];
	logic [2:0]  len_nxt;
	logic        rate_fire;
	logic [15:0] res_w [4];

	wire [3:0] op = cmd_r[0][7:4];
	wire [3:0] zyxt = cmd_r[0][3:0];
	wire op_sb = op == OP_SB;
	wire op_swoc = op == OP_SWOC;
	wire op_sm = op == OP_SM;
	wire op_rm = op == OP_RM;
	wire op_known = op inside {OP_NOP, OP_SB, OP_SWOC, OP_SM, OP_RM,
		OP_RR, OP_WR, OP_EX, OP_HR, OP_HS, OP_RT};
	wire [5:0] rr_addr = cmd_r[1][7:2];
	wire [5:0] wr_addr6 = cmd_r[3][7:2];
	wire [15:0] rr_word = rr_addr[5] ? 16'h0000 : vol_r[rr_addr[4:0]];
	wire exec_err = (op == OP_EX && sm_r) ||
		(op_sb && (woc_r || sm_r)) ||
		(op_swoc && (burst_r || sm_r)) ||
		(op_sm && (burst_r || woc_r || sm_r)) ||
		(op_rm && (!ready_r || rm_done_r)) ||
		(op == OP_WR && wr_addr6[5]) || !op_known;
	wire exec_ok = exec_r & ~exec_err;
	wire trig_go = trig_en & ~trig_dir & trig_rise &
		~(burst_r | woc_r | sm_r);
	wire exec_go = exec_ok & (op_sb | op_swoc | op_sm);
	wire start_req = (exec_go | trig_go | rate_fire) & ~active_r;
	wire [3:0] sel_axes = (zyxt == 4'h0) ? def_axes : zyxt;
	wire [3:0] start_axes = trig_go ? def_axes :
		rate_fire ? meas_axes : op_sm ? zyxt : sel_axes;

	assign do_recall = exec_ok & (op == OP_HR || op == OP_RT);
	assign do_store = exec_ok & (op == OP_HS);
	assign do_write = exec_ok & (op == OP_WR);
	assign wr_addr = wr_addr6[4:0];
	assign wr_data = {cmd_r[1], cmd_r[2]};
	assign res_w[0] = result_z;
	assign res_w[1] = result_y;
	assign res_w[2] = result_x;
	assign res_w[3] = result_t;

	always_comb begin
		resp_nxt = '{default: 8'h00};
		len_nxt = 3'h0;
		if (op == OP_RR) begin
			resp_nxt[0] = rr_word[15:8];
			resp_nxt[1] = rr_word[7:0];
			len_nxt = 3'h1;
		end
		if (op_rm) begin
			for (int k = 0; k < 4; k++) begin
				if (zyxt[3 - k]) begin
					resp_nxt[{len_nxt[1:0], 1'b0}] = res_w[k][15:8];
					resp_nxt[{len_nxt[1:0], 1'b1}] = res_w[k][7:0];
					len_nxt = len_nxt + 3'h1;
				end
			end
		end
	end

	cfgmag_repeat #(.STEP(REPEAT_STEP)) u_rate (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.run      (burst_r | woc_r),
		.done     (meas_done),
		.interval (rate_f),
		.fire     (rate_fire)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			burst_r <= 1'b0;
			woc_r <= 1'b0;
			sm_r <= 1'b0;
			err_r <= 1'b0;
			rs_r <= 1'b0;
			ready_r <= 1'b0;
			active_r <= 1'b0;
			rm_done_r <= 1'b0;
			len_r <= 3'h0;
			data_r <= '{default: 8'h00};
			meas_start <= 1'b0;
			meas_axes <= 4'h0;
			pend_r <= 1'b0;
			stale_r <= 1'b0;
		end else begin
			meas_start <= start_req;
			if (exec_r) begin
				err_r <= exec_err;
				rs_r <= exec_ok & (op == OP_RT);
				data_r <= resp_nxt;
				len_r <= exec_err ? 3'h0 : len_nxt;
				pend_r <= 1'b1;
				stale_r <= 1'b0;
			end else if (i2c_addr_byte && addr_match) begin
				pend_r <= 1'b0;
				stale_r <= rx_nxt[0] & ~pend_r;
			end
			if (exec_ok) begin
				case (op)
					OP_EX: begin
						burst_r <= 1'b0;
						woc_r <= 1'b0;
					end
					OP_SB:   burst_r <= 1'b1;
					OP_SWOC: woc_r <= 1'b1;
					OP_SM:   sm_r <= 1'b1;
					OP_RM:   rm_done_r <= 1'b1;
					OP_RT: begin
						burst_r <= 1'b0;
						woc_r <= 1'b0;
						sm_r <= 1'b0;
					end
					default: ;
				endcase
			end
			if (trig_go)
				sm_r <= 1'b1;
			if (start_req) begin
				meas_axes <= start_axes;
				active_r <= 1'b1;
				ready_r <= 1'b0;
			end
			if (meas_done) begin
				ready_r <= 1'b1;
				active_r <= 1'b0;
				rm_done_r <= exec_ok & op_rm;
				sm_r <= trig_go | (exec_ok & op_sm);
			end
		end
	end

	wire [2:0] eff_len = stale_r ? 3'h0 : len_r;
	wire [3:0] data_idx = idx_r - 4'h1;
	wire [7:0] status = {burst_r, woc_r, sm_r, err_r | stale_r, 1'b0,
		rs_r, eff_len[1:0]};

	assign tx_byte = (idx_r == 4'h0) ? status :
		(data_idx < {eff_len, 1'b0}) ? data_r[data_idx[2:0]] : 8'h00;
	assign result_ready_flag = ready_r;
	assign wake_on_change_mode = woc_r;
	assign trig_out = ready_r;
	assign trig_oe_n = ~trig_dir;
endmodule
`default_nettype wire

// ### cfgmag_port_assertions.sv
// checker: relations between the host port outputs
`timescale 1ns/100ps
`default_nettype none
module cfgmag_port_assertions (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        meas_start,
	input wire logic        meas_done,
	input wire logic        result_ready_flag,
	input wire logic        trig_out,
	input wire logic        sda_oe_n,
	input wire logic        temp_comp_enable,
	input wire logic [6:0]  spin_phase_clocks,
	input wire logic [3:0]  chop_periods,
	input wire logic [9:0]  mag_decimation,
	input wire logic [7:0]  average_count,
	input wire logic        cfg_pair_invalid,
	input wire logic [15:0] offset_x
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	property p_spin;
		$onehot(spin_phase_clocks[6:3]) && spin_phase_clocks[2:0] == 3'h0;
	endproperty
	a_spin: assert property (p_spin) else $error("spin length");
	property p_chop;
		$onehot(chop_periods);
	endproperty
	a_chop: assert property (p_chop) else $error("chop count");
	property p_dflt;
		$fell(sys_rst) |-> spin_phase_clocks == 7'h40 && chop_periods == 4'h1;
	endproperty
	a_dflt: assert property (p_dflt) else $error("spin default");
	property p_decim;
		$onehot(mag_decimation[9:6]) && mag_decimation[5:0] == 6'h00;
	endproperty
	a_decim: assert property (p_decim) else $error("decimation");
	property p_pair;
		cfg_pair_invalid == ((mag_decimation == 10'h040 &&
			average_count <= 8'h02) || (mag_decimation == 10'h080 &&
			average_count == 8'h01));
	endproperty
	a_pair: assert property (p_pair) else $error("pair flag");
	property p_ofs;
		!temp_comp_enable |-> offset_x == 16'h0000;
	endproperty
	a_ofs: assert property (p_ofs) else $error("offset leak");
	property p_set;
		meas_done |=> result_ready_flag && trig_out;
	endproperty
	a_set: assert property (p_set) else $error("ready not set");
	property p_clr;
		meas_start |=> !result_ready_flag;
	endproperty
	a_clr: assert property (p_clr) else $error("ready not clear");
	property p_pulse;
		meas_start |=> !meas_start;
	endproperty
	a_pulse: assert property (p_pulse) else $error("start width");
	cover property (meas_start);
	cover property ($fell(sda_oe_n));
	cover property (meas_done ##1 result_ready_flag);
endmodule
`default_nettype wire

// ### cfgmag_host_model.sv
// host master model on the serial pins, i2c and spi mode 3
`timescale 1ns/100ps
`default_nettype none
module cfgmag_host_model (
	input  wire logic clk,
	input  wire logic sda_line,
	input  wire logic miso_line,
	output var  logic sclk_pin,
	output var  logic cs_n_pin,
	output var  logic sda_drv
);
	initial begin
		sclk_pin = 1'b1;
		cs_n_pin = 1'b1;
		sda_drv  = 1'b1;
	end
	////////////////////////////////////////
	task automatic half();
		repeat (6) @(negedge clk);
	endtask
	// data moves while clock low, sampled late in high phase
	task automatic bitx(input logic o, output logic i);
		sclk_pin = 1'b0;
		repeat (2) @(negedge clk);
		sda_drv = o;
		repeat (4) @(negedge clk);
		sclk_pin = 1'b1;
		half();
		i = cs_n_pin ? sda_line : miso_line;
	endtask
	task automatic sel(input logic v);
		cs_n_pin = v;
		sda_drv  = 1'b1;
		half();
	endtask
	task automatic pins(input logic c, input logic s);
		sclk_pin = c;
		sda_drv  = s;
		half();
	endtask
	task automatic start();
		pins(1'b0, 1'b1);
		pins(1'b1, 1'b1);
		pins(1'b1, 1'b0);
	endtask
	task automatic stop();
		pins(1'b0, 1'b1);
		pins(1'b0, 1'b0);
		pins(1'b1, 1'b0);
		pins(1'b1, 1'b1);
	endtask
endmodule
`default_nettype wire

// ### cfgmag_port_tb_top.sv
// bench: host model on the serial pins, checks on the decodes
`timescale 1ns/100ps
`default_nettype none
module cfgmag_port_tb_top;
	import cfgmag_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        done = 1'b0;
	logic        trig = 1'b0;
	logic [31:0] seed = 32'h712964C2;
	logic [31:0] d = 32'h0;
	logic [39:0] r;
	logic [15:0] res, ofs, wt;
	logic [9:0]  mdec, tdec;
	logic [5:0]  win;
	logic [7:0]  avg;
	logic [6:0]  spin;
	logic [4:0]  a;
	logic [3:0]  ax, axes, ax_seen;
	logic [1:0]  ap;
	logic        sclk, cs_n, sda_drv, sda_out, sda_oe_n, miso, miso_oe_n;
	logic        mstart, trig_oe_n;
	int          fails = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          starts = 0;
	int          tstart, t0;
	wire logic   sda_line = sda_drv & (sda_oe_n | sda_out);
	wire logic   miso_line = miso_oe_n ? ~miso : miso;
	cfgmag_port #(.REPEAT_STEP(20)) i_dut (.clk, .sys_rst,
		.sclk_pin(sclk), .cs_n_pin(cs_n), .sda_in(sda_line), .sda_out,
		.sda_oe_n, .miso_out(miso), .miso_oe_n,
		.addr_select_pin_low(ap[0]), .addr_select_pin_high(ap[1]),
		.trig_in(trig), .trig_out(), .trig_oe_n, .meas_start(mstart),
		.meas_axes(axes), .meas_done(done), .result_z(res), .result_y(res),
		.result_x(res), .result_t(res), .temp_above_35c(d[0]),
		.result_ready_flag(), .wake_on_change_mode(),
		.change_compare_relative(), .spin_phase_clocks(spin),
		.chop_periods(), .mag_decimation(mdec), .temp_decimation(tdec),
		.average_count(avg), .cfg_pair_invalid(), .axis_output_window(win),
		.temp_comp_enable(), .sens_drift_active(), .offset_x(ofs),
		.offset_y(), .offset_z(), .wake_xy_threshold(),
		.wake_zaxis_threshold(), .wake_temp_threshold(wt));
	cfgmag_host_model i_host (.clk, .sda_line, .miso_line,
		.sclk_pin(sclk), .cs_n_pin(cs_n), .sda_drv);
	always #2 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	always @(negedge clk) begin
		if (mstart) begin
			starts++;
			tstart = cyc;
			ax_seen = axes;
		end
	end
	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic spi(input logic [39:0] c, output logic [39:0] q);
		i_host.sel(1'b0);
		for (int k = 39; k >= 0; k--) i_host.bitx(c[k], q[k]);
		i_host.sel(1'b1);
	endtask
	task automatic wr(input logic [4:0] w, input logic [15:0] v);
		spi({OP_WR, 4'h0, v, 1'b0, w, 2'b00, 8'h00}, r);
	endtask
	task automatic rr(input logic [4:0] w, input logic [15:0] e);
		spi({OP_RR, 4'h0, 1'b0, w, 2'b00, 24'h0}, r);
		chk("word", e, r[15:0]);
		chk("count", 16'h0001, {14'h0, r[17:16]});
	endtask
	task automatic cmd(input logic [7:0] c);
		spi({c, 32'h0}, r);
	endtask
	task automatic send9(input logic [8:0] o, output logic [8:0] q);
		for (int k = 8; k >= 0; k--) i_host.bitx(o[k], q[k]);
	endtask
	task automatic i2c(input logic [6:0] w, input logic [7:0] c,
		input logic e);
		logic [8:0] q;
		i_host.start();
		send9({w, 2'b01}, q);
		chk("ack", {15'h0, e}, {15'h0, ~q[0]});
		send9({c, 1'b1}, q);
		i_host.stop();
		i_host.start();
		send9({w, 2'b11}, q);
		send9(9'h1FF, q);
		i_host.stop();
		chk("status", {13'h0, e ? 3'h0 : 3'h7}, {13'h0, q[5], q[2:1]});
	endtask
	task automatic fin();
		done = 1'b1;
		@(negedge clk);
		done = 1'b0;
	endtask
	task automatic await(input int n);
		for (int k = 0; k < 200 && starts < n; k++) @(negedge clk);
	endtask
	task automatic final_report();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		final_report();
	end
	initial begin
		d = rnd();
		ap = d[1:0];
		res = d[31:16];
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		repeat (8) @(negedge clk);
		chk("spin", 16'h0040, {9'h0, spin});
		wr(5'h0A, 16'h1234);
		cmd({OP_HS, 4'h0});
		wr(5'h0A, 16'hA5C3);
		rr(5'h0A, 16'hA5C3);
		cmd({OP_HR, 4'h0});
		rr(5'h0A, 16'h1234);
		for (int i = 0; i < 3; i++) begin
			d = rnd();
			a = 5'h0A + d[20:16] % 5'h16;
			wr(a, d[15:0]);
			rr(a, d[15:0]);
		end
		d = rnd();
		d[3] = 1'b1;
		wr(W_CONV, d[15:0]);
		chk("decim", 16'h0040 << d[1:0], {6'h00, mdec});
		chk("average", 16'h0001 << d[4:2], {8'h00, avg});
		chk("temp decim", 16'h0040 << d[12:11], {6'h00, tdec});
		chk("window", {10'h0, d[10:5]}, {10'h0, win});
		wr(W_OFS_X, d[31:16]);
		chk("offset", 16'h0000, ofs);
		wr(W_MODE, 16'h0400);
		chk("offset", d[31:16], ofs);
		wr(W_WAKE_T, d[31:16]);
		chk("wake temp", d[31:16], wt);
		i2c({5'h03, ap}, 8'h00, 1'b1);
		i2c({5'h03, ~ap}, 8'h00, 1'b0);
		wr(W_MODE, 16'h4000);
		i2c({5'h03, ap}, 8'h00, 1'b0);
		wr(W_MODE, 16'h6000);
		i2c({5'h03, ap}, {OP_RT, 4'h0}, 1'b1);
		rr(W_MODE, 16'h0000);
		ax = d[3:0] | 4'h1;
		wr(W_MODE, {4'h0, 2'b10, ax, 6'h02});
		chk("pin dir", 16'h0001, {15'h0, trig_oe_n});
		cmd({OP_SB, 4'h0});
		await(1);
		chk("axes", {12'h0, ax}, {12'h0, ax_seen});
		fin();
		t0 = cyc;
		await(2);
		chk("gap", 16'h0001, {15'h0, (tstart - t0) inside {[40:48]}});
		cmd({OP_EX, 4'h0});
		fin();
		trig = 1'b1;
		await(3);
		chk("trigger", {10'h0, 2'h3, ax}, {10'h0, starts[1:0], ax_seen});
		fin();
		trig = 1'b0;
		wr(W_MODE, 16'h8800);
		chk("pin dir", 16'h0000, {15'h0, trig_oe_n});
		trig = 1'b1;
		repeat (30) @(negedge clk);
		chk("starts", 16'h0003, starts[15:0]);
		final_report();
	end
endmodule
bind cfgmag_port cfgmag_port_assertions i_chk (.clk, .sys_rst, .meas_start,
	.meas_done, .result_ready_flag, .trig_out, .sda_oe_n, .temp_comp_enable,
	.spin_phase_clocks, .chop_periods, .mag_decimation, .average_count,
	.cfg_pair_invalid, .offset_x);
`default_nettype wire
